//--- rtl/ccd_readout_map.svh
// Constants for the row readout sequencer: counts, compare values and preloads.
`ifndef CCD_READOUT_MAP_SVH
`define CCD_READOUT_MAP_SVH

// Pixel periods in one complete horizontal row readout.
`define LINE_TOTAL_PIXELS 12'h197
// Pixel periods that can carry photo-generated charge.
`define ACTIVE_PIXELS 12'h181
// Pixel count that closes the active-line interval (384).
`define ACTIVE_END_COUNT 12'h180
// Pixel counter preload, the hard-wired negative offset (-20).
`define PIXEL_PRELOAD 12'hfec
// Width of the pixel counter.
`define PIXEL_W 12

// Vertical counter width and its frame transfer preload (-291).
`define VERT_W 10
`define VERT_PRELOAD 10'h2dd
// Vertical count that reads -1 and ends frame transfer.
`define VERT_FT_LAST 10'h3ff
// Last storage row of the frame, for the catch-all end compare (287).
`define VERT_LAST_ROW 12'h11f

// Vertical divider: system clock divided by 6, row advance and gate phases.
`define DIV_RATIO 3'h6
`define DIV_ADVANCE_PHASE 3'h2
`define DIV_GATE_PHASE 3'h5

// Black reference shift register length, tap position and pulse width.
`define BLACK_SR_W 16
`define BLACK_TAP 8
`define BLACK_WIDTH 4

// Delay of the window-active signal in clock periods.
`define WIN_DELAY 2

`endif

//--- rtl/ccd_readout_pkg.sv
// Types shared by the row readout sequencer.
package ccd_readout_pkg;

  // Sequencer phases of one frame: restart, transfer, settle, readout, resume.
  typedef enum logic [2:0] {
    st_idle,
    st_frame,
    st_settle,
    st_horiz_start_pulse,
    st_hread,
    st_hdone,
    st_storage
  } seq_state_t;

endpackage

//--- rtl/ccd_row_readout_sequencer.sv
// Horizontal and vertical readout sequencer for a frame transfer image sensor.
`timescale 1ns/1ns
`include "ccd_readout_map.svh"

module ccd_row_readout_sequencer
  import ccd_readout_pkg::*;
#(
  parameter logic [`PIXEL_W-1:0] pixel_preload_straps = `PIXEL_PRELOAD,
  parameter int black_tap = `BLACK_TAP
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic line_reset_n,
  input wire logic bitmap_row_stop_bit,
  input wire logic bitmap_row_data_bit,
  input wire logic bitmap_frame_end_bit,
  input wire logic [3:0] window_id,
  input wire logic bitmap_ctr_load_n,
  input wire logic bitmap_ctr_count_en,
  input wire logic [`PIXEL_W-1:0] bitmap_ctr_value,
  output logic horiz_run_n,
  output logic storage_run_n,
  output logic image_run_n,
  output logic horiz_start_pulse,
  output logic line_end_n,
  output logic active_end_n,
  output logic active_line_n,
  output logic black_ref_n,
  output logic frame_sync_n,
  output logic dump_row_n,
  output logic [3:0] window_id_out,
  output logic window_active_n,
  output logic [`PIXEL_W-1:0] pixel_count,
  output logic [`VERT_W-1:0] vert_count,
  output logic vert_gate_pulse,
  output logic row_advance_pulse
);

  // Eight bit compare on bits 8:1, enabled only for a positive count.
  function automatic logic cmp8(input logic [`PIXEL_W-1:0] count, input logic [`PIXEL_W-1:0] target);
    cmp8 = !count[`PIXEL_W-1] && (count != '0) && (count[8:1] == target[8:1]);
  endfunction

  seq_state_t state; // Current sequencer phase.
  logic [2:0] div_count; // Vertical divider phase, 0 to 5.
  logic active_q; // Active-line interval, before dump masking.
  logic [`BLACK_SR_W-1:0] black_sr; // History of horizontal run.
  logic [`WIN_DELAY-1:0] win_delay; // Window-active delay stages.
  logic [3:0] window_q; // Window identifiers sampled from the bitmap.
  logic line_end; // Line-end comparator output.
  logic active_end; // Active-end comparator output.
  logic frame_end; // Catch-all or bitmap frame end at the gate.
  logic win_any; // Any gated window identifier nonzero.
  logic black_pulse; // Raw black reference window from the shift register.

  // Comparators read the registered counters, so their outputs settle early.
  // LSB-blind compares
  assign line_end = cmp8(pixel_count, `LINE_TOTAL_PIXELS);
  assign active_end = cmp8(pixel_count, `ACTIVE_END_COUNT);
  assign line_end_n = !line_end;
  assign active_end_n = !active_end;

  // The storage end compare uses the same decoder on the sign-extended row count.
  assign frame_end = bitmap_frame_end_bit
    || cmp8({{(`PIXEL_W-`VERT_W){vert_count[`VERT_W-1]}}, vert_count}, `VERT_LAST_ROW);

  // Divider phases give two pulses per vertical period.
  // divider pulses
  assign row_advance_pulse = !storage_run_n && (div_count == `DIV_ADVANCE_PHASE);
  assign vert_gate_pulse = !storage_run_n && (div_count == `DIV_GATE_PHASE);

  // Dump rows must never look like live data, so the masks sit after the flops.
  // dump masks
  assign active_line_n = !(active_q && dump_row_n);
  assign window_id_out = active_line_n ? 4'h0 : window_q;
  assign win_any = |window_id_out;
  assign window_active_n = !win_delay[`WIN_DELAY-1];

  assign black_pulse = black_sr[black_tap] && !black_sr[black_tap+`BLACK_WIDTH];
  assign black_ref_n = !(black_pulse && dump_row_n);

  // Main sequencer: owns the run signals, frame sync and the start pulse.
  // Line reset low parks everything so the bitmap can be programmed safely.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= st_idle;
      horiz_run_n <= 1'b1;
      storage_run_n <= 1'b1;
      image_run_n <= 1'b1;
      horiz_start_pulse <= 1'b0;
      frame_sync_n <= 1'b0;
    end else if (clk_en) begin
      horiz_start_pulse <= 1'b0;
      if (!line_reset_n) begin
        // Camera halted: all runs inactive, restart from frame transfer later.
        state <= st_idle;
        horiz_run_n <= 1'b1;
        storage_run_n <= 1'b1;
        image_run_n <= 1'b1;
        frame_sync_n <= 1'b0;
      end else begin
        unique case (state)
          st_idle: begin
            if (horiz_run_n && storage_run_n) begin
              storage_run_n <= 1'b0;
              image_run_n <= 1'b0;
              frame_sync_n <= 1'b0;
              state <= st_frame;
            end
          end
          st_frame: begin
            if (vert_count == `VERT_FT_LAST) begin
              storage_run_n <= 1'b1;
              image_run_n <= 1'b1;
              state <= st_settle;
            end
          end
          st_settle: begin
            // First settling clock after the vertical halt.
            // start pulse
            horiz_start_pulse <= 1'b1;
            state <= st_horiz_start_pulse;
          end
          st_horiz_start_pulse: begin
            horiz_run_n <= 1'b0;
            state <= st_hread;
          end
          st_hread: begin
            // Every period is clocked out before the run drops.
            // full row
            if (line_end) begin
              horiz_run_n <= 1'b1;
              state <= st_hdone;
            end
          end
          st_hdone: begin
            storage_run_n <= 1'b0;
            frame_sync_n <= 1'b1;
            state <= st_storage;
          end
          st_storage: begin
            // Row decisions are taken only at the gate, once the transfer is complete.
            if (vert_gate_pulse) begin
              if (frame_end) begin
                // Last row reached: straight into the next frame transfer.
                image_run_n <= 1'b0;
                frame_sync_n <= 1'b0;
                state <= st_frame;
              end else if (bitmap_row_stop_bit) begin
                storage_run_n <= 1'b1;
                state <= st_settle;
              end
            end
          end
        endcase
      end
    end
  end

  // Vertical divider, held at its load value while storage run is inactive.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_count <= 3'h0;
    end else if (clk_en) begin
      if (storage_run_n) begin
        div_count <= 3'h0;
      end else if (div_count == `DIV_RATIO - 3'h1) begin
        div_count <= 3'h0;
      end else begin
        div_count <= div_count + 3'h1;
      end
    end
  end

  // Vertical counter: negative through frame transfer, then the storage row number.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vert_count <= `VERT_PRELOAD;
    end else if (clk_en) begin
      if (state == st_idle || (state == st_storage && vert_gate_pulse && frame_end)) begin
        vert_count <= `VERT_PRELOAD;
      end else if (row_advance_pulse) begin
        vert_count <= vert_count + {{(`VERT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Pixel counter: preload while idle, count while the horizontal run is active.
  // With line reset low the bitmap loader drives it for auto-increment access.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pixel_count <= `PIXEL_PRELOAD;
    end else if (clk_en) begin
      if (!line_reset_n) begin
        if (!bitmap_ctr_load_n) begin
          pixel_count <= bitmap_ctr_value;
        end else if (bitmap_ctr_count_en) begin
          pixel_count <= pixel_count + {{(`PIXEL_W-1){1'b0}}, 1'b1};
        end
      end else if (horiz_run_n) begin
        pixel_count <= pixel_preload_straps;
      end else begin
        pixel_count <= pixel_count + {{(`PIXEL_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Active-line flag, set as the counter rolls to zero and cleared at the end compare.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= 1'b0;
    end else if (clk_en) begin
      if (horiz_run_n || active_end) begin
        active_q <= 1'b0;
      end else if (pixel_count == {`PIXEL_W{1'b1}}) begin
        active_q <= 1'b1;
      end
    end
  end

  // Dump-row flag: forced during frame transfer, sampled from the bitmap at the gate.
  // Forcing it in transfer is what keeps the first readout free of events.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dump_row_n <= 1'b0;
    end else if (clk_en) begin
      if (state == st_frame || state == st_idle) begin
        dump_row_n <= 1'b0;
      end else if (state == st_storage && vert_gate_pulse) begin
        dump_row_n <= bitmap_row_data_bit;
      end
    end
  end

  // Black reference history of the horizontal run.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      black_sr <= '0;
    end else if (clk_en) begin
      black_sr <= {black_sr[`BLACK_SR_W-2:0], !horiz_run_n};
    end
  end

  // Window identifiers are sampled once, then gated by the active-line interval.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      window_q <= 4'h0;
    end else if (clk_en) begin
      window_q <= window_id;
    end
  end

  // Window-active delay line, cleared whenever the active line is inactive (active_line_n high).
  // Clearing rather than masking stops a stale window leaking past the line end.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_delay <= '0;
    end else if (clk_en) begin
      if (active_line_n) begin
        win_delay <= '0;
      end else begin
        win_delay <= {win_delay[`WIN_DELAY-2:0], win_any};
      end
    end
  end

  a_line_stop: assert property (@(posedge ref_clk) disable iff (!rst_b || !clk_en || !line_reset_n)
    (line_end && !horiz_run_n && state == st_hread) |=> horiz_run_n)
    else $error("Horizontal run did not drop after line end.");

  a_vrun_resume: assert property (@(posedge ref_clk) disable iff (!rst_b || !clk_en || !line_reset_n)
    $rose(horiz_run_n) |=> !storage_run_n && frame_sync_n)
    else $error("Storage run not resumed one clock after readout.");

  a_horiz_run_n_settle: assert property (@(posedge ref_clk) disable iff (!rst_b || !clk_en || !line_reset_n)
    $rose(storage_run_n) |-> horiz_run_n ##1 (horiz_run_n && horiz_start_pulse) ##1 !horiz_run_n)
    else $error("Horizontal run not two clocks after vertical halt.");

  a_start_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b || !clk_en || !line_reset_n)
    horiz_start_pulse |=> !horiz_start_pulse && !horiz_run_n && pixel_count == pixel_preload_straps)
    else $error("Start pulse did not begin the pixel count.");

  a_dump_masks: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !dump_row_n |-> active_line_n && black_ref_n && window_id_out == 4'h0)
    else $error("Dump row produced active line or black reference.");

  a_black_width: assert property (@(posedge ref_clk) disable iff (!rst_b || !clk_en || !line_reset_n)
    $fell(black_ref_n) && dump_row_n |-> (!black_ref_n || !dump_row_n)[*4] ##1 black_ref_n)
    else $error("Black reference pulse is not four clocks wide.");

  a_restart: assert property (@(posedge ref_clk) disable iff (!rst_b || !clk_en || !line_reset_n)
    (horiz_run_n && storage_run_n && state == st_idle) |=> !storage_run_n && !image_run_n)
    else $error("Idle sequencer did not force vertical run.");

  a_frame_end: assert property (@(posedge ref_clk) disable iff (!rst_b || !clk_en || !line_reset_n)
    (state == st_frame && vert_count == `VERT_FT_LAST) |=> storage_run_n && image_run_n)
    else $error("Frame transfer did not end at count -1.");

  a_win_delay: assert property (@(posedge ref_clk) disable iff (!rst_b || !clk_en)
    (!active_line_n)[*3] |-> window_active_n == !$past(win_any, 2))
    else $error("Window active is not the two-clock delayed OR.");

  a_active_end: assert property (@(posedge ref_clk) disable iff (!rst_b || !clk_en)
    (active_end && !horiz_run_n) |=> active_line_n)
    else $error("Active line still high after count 384.");

endmodule // ccd_row_readout_sequencer

//--- bench/bitmap_model.sv
// Behavioural bitmap lookup model that supplies row-action bits to the sequencer.
`timescale 1ns/1ns

module bitmap_model #(
  parameter logic [9:0] data_row = 10'h004,
  parameter logic [9:0] dump_row = 10'h006
) (
  input wire logic [9:0] vert_count,
  input wire logic frame_sync_n,
  output logic row_stop,
  output logic row_data
);
  // The bitmap is only enabled while frame sync is high, so both bits read zero in frame transfer.
  // row stop
  assign row_stop = frame_sync_n & ((vert_count == data_row) | (vert_count == dump_row));
  assign row_data = frame_sync_n & (vert_count == data_row);
endmodule // bitmap_model

//--- bench/testbench.sv
// Self-checking bench for the row readout sequencer, one task per scenario.
`timescale 1ns/1ns

module testbench;
  import ccd_readout_pkg::*;

  logic ref_clk, rst_b, line_reset_n, row_stop, row_data, ctr_load_n, ctr_count_en;
  logic [3:0] window_id, window_id_out;
  logic [11:0] ctr_value, pixel_count;
  logic [9:0] vert_count;
  logic horiz_run_n, storage_run_n, image_run_n, horiz_start_pulse, line_end_n, active_end_n;
  logic active_line_n, black_ref_n, frame_sync_n, dump_row_n, window_active_n;
  logic vert_gate_pulse, row_advance_pulse;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  ccd_row_readout_sequencer ccd_row_readout_sequencer_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .line_reset_n(line_reset_n),
    .bitmap_row_stop_bit(row_stop), .bitmap_row_data_bit(row_data), .bitmap_frame_end_bit(1'b0),
    .window_id(window_id), .bitmap_ctr_load_n(ctr_load_n), .bitmap_ctr_count_en(ctr_count_en),
    .bitmap_ctr_value(ctr_value), .horiz_run_n(horiz_run_n), .storage_run_n(storage_run_n),
    .image_run_n(image_run_n), .horiz_start_pulse(horiz_start_pulse), .line_end_n(line_end_n),
    .active_end_n(active_end_n), .active_line_n(active_line_n), .black_ref_n(black_ref_n),
    .frame_sync_n(frame_sync_n), .dump_row_n(dump_row_n), .window_id_out(window_id_out),
    .window_active_n(window_active_n), .pixel_count(pixel_count), .vert_count(vert_count),
    .vert_gate_pulse(vert_gate_pulse), .row_advance_pulse(row_advance_pulse)
  );

  bitmap_model bitmap_model_inst (
    .vert_count(vert_count), .frame_sync_n(frame_sync_n), .row_stop(row_stop), .row_data(row_data)
  );

  // Free-running 125 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Cuts a hang short; the frame transfer plus three readouts needs well under this.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      conclude();
    end
  end

  // Compares one observed value with its expectation and counts the result.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Holds reset for 20 cycles, checks the idle outputs, then sees the restart.
  task automatic reset_scenario();
    rst_b = 1'b0;
    repeat (20) @(negedge ref_clk);
    check("horiz_run_n_rst", horiz_run_n, 1'b1);
    check("storage_run_n_rst", storage_run_n, 1'b1);
    check("pix_rst", pixel_count, 12'hfec);
    check("vert_rst", vert_count, 10'h2dd);
    rst_b = 1'b1;
    @(negedge ref_clk);
    check("storage_run_n_restart", storage_run_n, 1'b0);
    check("image_run_n_restart", image_run_n, 1'b0);
    check("frame_sync_n_ft", frame_sync_n, 1'b0);
  endtask

  // Follows one horizontal readout from the start pulse to the vertical restart.
  task automatic watch_readout(input logic [9:0] row, input logic act, input int gates);
    int n;
    int g;
    int al;
    int bl;
    logic ws;
    n = 0;
    g = 0;
    // Gate pulses are counted on the way, one per storage row passed.
    while (horiz_start_pulse !== 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
      if (vert_gate_pulse === 1'b1) g++;
    end
    check("start_seen", horiz_start_pulse, 1'b1);
    check("gate_count", g, gates);
    check("start_row", vert_count, row);
    check("storage_run_n_halt", storage_run_n, 1'b1);
    check("dump_flag", dump_row_n, act);
    @(negedge ref_clk);
    check("horiz_run_n_low", horiz_run_n, 1'b0);
    check("pix_first", pixel_count, 12'hfec);
    al = 0;
    bl = 0;
    ws = 1'b0;
    n = 0;
    while (horiz_run_n === 1'b0 && n < 600) begin
      if (active_line_n === 1'b0) al++;
      else check("id_zero", window_id_out, 4'h0);
      if (black_ref_n === 1'b0) bl++;
      if (window_active_n === 1'b0) ws = 1'b1;
      if (active_line_n === 1'b0 && window_id_out !== 4'h5) check("id_pass", window_id_out, 4'h5);
      if (pixel_count == 12'h000) check("line_at_zero", active_line_n, !act);
      if (pixel_count == 12'h180) check("act_end", active_end_n, 1'b0);
      @(negedge ref_clk);
      n++;
    end
    check("horiz_run_n_end", horiz_run_n, 1'b1);
    check("active_len", al, act ? 385 : 0);
    check("black_len", bl, act ? 4 : 0);
    check("win_seen", ws, act);
    check("end_count", pixel_count, 12'h197);
    check("line_end", line_end_n, 1'b0);
    @(negedge ref_clk);
    check("storage_run_n_resume", storage_run_n, 1'b0);
    check("pix_reload", pixel_count, 12'hfec);
  endtask

  // Frame transfer, the forced dump readout, then a data row and a dump row.
  task automatic frame_scenario();
    int n;
    int adv;
    n = 0;
    adv = 0;
    // Every row advance of the transfer is counted; -291 to -1 takes 290 of them.
    while (storage_run_n !== 1'b1 && n < 3000) begin
      if (row_advance_pulse === 1'b1) adv++;
      @(negedge ref_clk);
      n++;
    end
    check("ft_wait", storage_run_n, 1'b1);
    check("ft_advances", adv, 290);
    check("ft_image_run_n_end", image_run_n, 1'b1);
    check("ft_last", vert_count, 10'h3ff);
    check("frame_sync_n_dump", frame_sync_n, 1'b0);
    watch_readout(10'h3ff, 1'b0, 0);
    check("frame_sync_n_on", frame_sync_n, 1'b1);
    watch_readout(10'h004, 1'b1, 5);
    watch_readout(10'h006, 1'b0, 2);
  endtask

  // Halts the camera, loads and counts the pixel counter, then restarts.
  task automatic halt_scenario();
    int n;
    line_reset_n = 1'b0;
    ctr_value = 12'h123;
    ctr_load_n = 1'b0;
    @(negedge ref_clk);
    check("ctr_load", pixel_count, 12'h123);
    ctr_load_n = 1'b1;
    ctr_count_en = 1'b1;
    @(negedge ref_clk);
    check("ctr_count", pixel_count, 12'h124);
    ctr_count_en = 1'b0;
    @(negedge ref_clk);
    check("ctr_hold", pixel_count, 12'h124);
    line_reset_n = 1'b1;
    n = 0;
    while (storage_run_n !== 1'b0 && n < 3) begin
      @(negedge ref_clk);
      n++;
    end
    check("halt_run", storage_run_n, 1'b0);
    check("halt_restart", image_run_n, 1'b0);
  endtask

  // Main sequence; every input has a value at time zero.
  initial begin
    rst_b = 1'b0;
    line_reset_n = 1'b1;
    window_id = 4'h5;
    ctr_load_n = 1'b1;
    ctr_count_en = 1'b0;
    ctr_value = 12'h000;
    @(negedge ref_clk);
    reset_scenario();
    frame_scenario();
    halt_scenario();
    conclude();
  end
endmodule // testbench
